// ### hw/isf_status_flags.sv
// status-flag logic of a two-wire bus controller
// assumes the shift engine reports bus events as one-cycle pulses on core_clk
// and stops shifting receive data while rx_stall is high
//
// The address-and-strobe port and the address map were chosen for this implementation.

`timescale 1ns/10ps

module isf_status_flags #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [isf_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_dbg,
  output logic [isf_pkg::DATA_W-1:0] reg_rdata,
  // interrupt
  output logic irq,
  // receive side of the shift engine
  input wire logic rx_byte_done,
  input wire logic [7:0] rx_byte,
  output logic rx_stall,
  // transmit side of the shift engine
  input wire logic tx_shift_empty,
  output logic tx_load,
  output logic [7:0] tx_data,
  // bus events from the shift engine
  input wire logic ev_start,
  input wire logic ev_rstart,
  input wire logic ev_stop,
  input wire logic ev_nack,
  input wire logic ev_own_match,
  input wire logic ev_gen_call,
  input wire logic ev_addr_mismatch,
  input wire logic ev_first_byte,
  // mode seen by the shift engine
  output logic module_run,
  output logic ten_bit_mode,
  output logic free_format_select,
  output logic fifo_mode
);

  // ==========================================
  // state
  typedef struct packed {
    logic [3:0] mode;
    logic receive_overrun_flag;
    logic tx_shift_not_empty;
    logic addressed_as_target;
    logic general_call_flag;
    logic stop_detected_flag;
    logic tx_holding_ready;
    logic rx_full;
    logic [7:0] rx_hold;
    logic pend_valid;
    logic [7:0] pend_byte;
    logic tx_valid;
    logic [7:0] tx_hold;
    logic tx_load;
    logic [7:0] tx_data;
    logic [isf_pkg::EV_W-1:0] irq_stat;
    logic [isf_pkg::EV_W-1:0] irq_mask;
    logic irq;
    logic [isf_pkg::DATA_W-1:0] rdata;
  } isf_state_t;

  isf_state_t s_q;
  isf_state_t s_d;

  logic [ADDR_W-1:0] a;
  logic mod_rst;
  logic [isf_pkg::DATA_W-1:0] status_view;
  logic [2:0] isrc_view;
  logic [isf_pkg::EV_W-1:0] ev;
  logic cpu_rd;

  assign a = reg_addr;
  // debug reads see the flags without disturbing them
  assign cpu_rd = reg_rd && !reg_dbg;
  assign mod_rst = !s_q.mode[isf_pkg::MD_RUN];

  // ==========================================
  // read views
  always_comb
  begin
    status_view = '0;
    status_view[isf_pkg::ST_OVERRUN] = s_q.receive_overrun_flag;
    status_view[isf_pkg::ST_TX_NOT_EMPTY] = s_q.tx_shift_not_empty;
    status_view[isf_pkg::ST_ADDR_TARGET] = s_q.addressed_as_target;
    status_view[isf_pkg::ST_GEN_CALL] = s_q.general_call_flag;
    status_view[isf_pkg::ST_STOP] = s_q.stop_detected_flag;
    status_view[isf_pkg::ST_TX_READY] = s_q.tx_holding_ready;
    status_view[isf_pkg::ST_RX_READY] = s_q.rx_full;
    isrc_view = s_q.stop_detected_flag ? isf_pkg::ISRC_STOP : isf_pkg::ISRC_NONE;
  end

  // ==========================================
  // next state
  always_comb
  begin
    s_d = s_q;
    ev = '0;
    s_d.tx_load = 1'b0;

    // mode register survives module reset so software can lift it again
    if (reg_wr && a == ADDR_W'(isf_pkg::OFS_MODE))
    begin
      s_d.mode = reg_wdata[3:0];
    end

    // ---------------- receive path
    if (rx_byte_done)
    begin
      if (!s_q.rx_full || (cpu_rd && a == ADDR_W'(isf_pkg::OFS_RXHOLD) && !s_q.pend_valid))
      begin
        s_d.rx_hold = rx_byte;
        s_d.rx_full = 1'b1;
      end
      else
      begin
        s_d.pend_valid = 1'b1;
        s_d.pend_byte = rx_byte;
        s_d.receive_overrun_flag = 1'b1;
        ev[isf_pkg::IE_OVERRUN] = 1'b1;
      end
    end
    else if (cpu_rd && a == ADDR_W'(isf_pkg::OFS_RXHOLD))
    begin
      s_d.receive_overrun_flag = 1'b0;
      if (s_q.pend_valid)
      begin
        // held-back byte moves up only once the old one is read
        s_d.rx_hold = s_q.pend_byte;
        s_d.pend_valid = 1'b0;
      end
      else
      begin
        s_d.rx_full = 1'b0;
      end
    end

    // ---------------- transmit path
    if (tx_shift_empty)
    begin
      if (s_q.tx_valid)
      begin
        s_d.tx_load = 1'b1;
        s_d.tx_data = s_q.tx_hold;
        s_d.tx_valid = 1'b0;
        if (!s_q.mode[isf_pkg::MD_FIFO])
        begin
          s_d.tx_holding_ready = 1'b1;
          ev[isf_pkg::IE_TX_READY] = 1'b1;
        end
      end
      else
      begin
        // no transfer: the shifter keeps its old byte
        s_d.tx_shift_not_empty = 1'b0;
        ev[isf_pkg::IE_UNDERFLOW] = 1'b1;
      end
    end
    // a write in the same cycle wins over the flag clear; the underflow event is still raised
    if (reg_wr && a == ADDR_W'(isf_pkg::OFS_TXHOLD))
    begin
      s_d.tx_hold = reg_wdata[7:0];
      s_d.tx_valid = 1'b1;
      s_d.tx_shift_not_empty = 1'b1;
      s_d.tx_holding_ready = 1'b0;
    end

    // ---------------- addressed-as-target, clears first so sets win
    if (ev_nack || ev_stop)
    begin
      s_d.addressed_as_target = 1'b0;
    end
    if (!s_q.mode[isf_pkg::MD_TEN_BIT] && ev_rstart)
    begin
      s_d.addressed_as_target = 1'b0;
    end
    if (s_q.mode[isf_pkg::MD_TEN_BIT] && ev_addr_mismatch)
    begin
      s_d.addressed_as_target = 1'b0;
    end
    if (ev_own_match || ev_gen_call || (ev_first_byte && s_q.mode[isf_pkg::MD_FREE_FMT]))
    begin
      s_d.addressed_as_target = 1'b1;
      ev[isf_pkg::IE_ADDR_TARGET] = !s_q.addressed_as_target;
    end

    // ---------------- general call
    if (ev_start || ev_rstart || ev_stop)
    begin
      s_d.general_call_flag = 1'b0;
    end
    if (ev_gen_call)
    begin
      s_d.general_call_flag = 1'b1;
    end

    // ---------------- stop detected
    if (cpu_rd && a == ADDR_W'(isf_pkg::OFS_ISRC) && isrc_view == isf_pkg::ISRC_STOP)
    begin
      s_d.stop_detected_flag = 1'b0;
    end
    if (reg_wr && a == ADDR_W'(isf_pkg::OFS_STATUS) && reg_wdata[isf_pkg::ST_STOP])
    begin
      s_d.stop_detected_flag = 1'b0;
    end
    if (ev_stop)
    begin
      s_d.stop_detected_flag = 1'b1;
      ev[isf_pkg::IE_STOP] = 1'b1;
    end

    // ---------------- interrupt status, write one to clear, set wins
    if (reg_wr && a == ADDR_W'(isf_pkg::OFS_IRQ_STAT))
    begin
      s_d.irq_stat = s_q.irq_stat & ~reg_wdata[isf_pkg::EV_W-1:0];
    end
    if (reg_wr && a == ADDR_W'(isf_pkg::OFS_IRQ_MASK))
    begin
      s_d.irq_mask = reg_wdata[isf_pkg::EV_W-1:0];
    end

    // ---------------- module reset holds the flags at their idle values
    if (mod_rst)
    begin
      s_d.receive_overrun_flag = 1'b0;
      s_d.tx_shift_not_empty = isf_pkg::TX_NOT_EMPTY_RESET;
      s_d.addressed_as_target = 1'b0;
      s_d.general_call_flag = 1'b0;
      s_d.stop_detected_flag = 1'b0;
      s_d.tx_holding_ready = isf_pkg::TX_READY_RESET;
      s_d.rx_full = 1'b0;
      s_d.pend_valid = 1'b0;
      s_d.tx_valid = 1'b0;
      s_d.tx_load = 1'b0;
      ev = '0;
    end
    s_d.irq_stat = s_d.irq_stat | ev;
    s_d.irq = |(s_d.irq_stat & s_d.irq_mask);

    // ---------------- read data, valid only in the cycle after the strobe
    s_d.rdata = '0;
    if (reg_rd)
    begin
      case (a)
        ADDR_W'(isf_pkg::OFS_STATUS): s_d.rdata = status_view;
        ADDR_W'(isf_pkg::OFS_MODE): s_d.rdata = {{(isf_pkg::DATA_W-4){1'b0}}, s_q.mode};
        ADDR_W'(isf_pkg::OFS_ISRC): s_d.rdata = {{(isf_pkg::DATA_W-3){1'b0}}, isrc_view};
        ADDR_W'(isf_pkg::OFS_RXHOLD): s_d.rdata = {8'h00, s_q.rx_hold};
        ADDR_W'(isf_pkg::OFS_TXHOLD): s_d.rdata = {8'h00, s_q.tx_hold};
        ADDR_W'(isf_pkg::OFS_IRQ_STAT): s_d.rdata = {{(isf_pkg::DATA_W-isf_pkg::EV_W){1'b0}}, s_q.irq_stat};
        ADDR_W'(isf_pkg::OFS_IRQ_MASK): s_d.rdata = {{(isf_pkg::DATA_W-isf_pkg::EV_W){1'b0}}, s_q.irq_mask};
        default: s_d.rdata = '0;
      endcase
    end
  end

  // ==========================================
  // registers
  always_ff @(posedge core_clk)
  begin
    if (!rst_b)
    begin
      s_q <= '0;
      s_q.mode <= isf_pkg::MODE_RESET;
      s_q.tx_shift_not_empty <= isf_pkg::TX_NOT_EMPTY_RESET;
      s_q.tx_holding_ready <= isf_pkg::TX_READY_RESET;
    end
    else if (clk_en)
    begin
      s_q <= s_d;
    end
  end

  // ==========================================
  // outputs
  assign reg_rdata = s_q.rdata;
  assign irq = s_q.irq;
  assign rx_stall = s_q.pend_valid;
  assign tx_load = s_q.tx_load;
  assign tx_data = s_q.tx_data;
  assign module_run = s_q.mode[isf_pkg::MD_RUN];
  assign ten_bit_mode = s_q.mode[isf_pkg::MD_TEN_BIT];
  assign free_format_select = s_q.mode[isf_pkg::MD_FREE_FMT];
  assign fifo_mode = s_q.mode[isf_pkg::MD_FIFO];

endmodule : isf_status_flags

// ### hw/isf_pkg.sv
// constants for the two-wire bus controller status-flag block
// assumes a single core clock and a plain register port from the cpu side

package isf_pkg;

  localparam int DATA_W = 16;

  // ==========================================
  // register offsets (byte addresses)
  localparam logic [7:0] OFS_STATUS = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_ISRC = 8'h08;
  localparam logic [7:0] OFS_RXHOLD = 8'h0C;
  localparam logic [7:0] OFS_TXHOLD = 8'h10;
  localparam logic [7:0] OFS_IRQ_STAT = 8'h14;
  localparam logic [7:0] OFS_IRQ_MASK = 8'h18;

  // ==========================================
  // status bit positions
  localparam int ST_OVERRUN = 11;
  localparam int ST_TX_NOT_EMPTY = 10;
  localparam int ST_ADDR_TARGET = 9;
  localparam int ST_GEN_CALL = 8;
  localparam int ST_STOP = 5;
  localparam int ST_TX_READY = 4;
  localparam int ST_RX_READY = 3;

  // ==========================================
  // mode control bit positions
  localparam int MD_RUN = 0;
  localparam int MD_TEN_BIT = 1;
  localparam int MD_FREE_FMT = 2;
  localparam int MD_FIFO = 3;
  localparam logic [3:0] MODE_RESET = 4'h0;

  // ==========================================
  // interrupt event bit positions
  localparam int EV_W = 5;
  localparam int IE_OVERRUN = 0;
  localparam int IE_UNDERFLOW = 1;
  localparam int IE_ADDR_TARGET = 2;
  localparam int IE_STOP = 3;
  localparam int IE_TX_READY = 4;

  // ==========================================
  // interrupt source codes
  localparam logic [2:0] ISRC_NONE = 3'h0;
  localparam logic [2:0] ISRC_STOP = 3'h6;

  // ==========================================
  // flag values taken on module reset
  localparam logic TX_NOT_EMPTY_RESET = 1'b1;
  localparam logic TX_READY_RESET = 1'b1;

endpackage : isf_pkg

// ### testbench/isf_status_flags_assertions.sv
// port checker for the status-flag block
// assumes one clock domain and binds to every isf_status_flags instance
`timescale 1ns/10ps
module isf_status_flags_assertions #(
  parameter int ADDR_W = 8
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic clk_en,
  // register port
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [isf_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic reg_dbg,
  input wire logic [isf_pkg::DATA_W-1:0] reg_rdata,
  input wire logic irq,
  // engine side
  input wire logic rx_stall,
  input wire logic tx_shift_empty,
  input wire logic tx_load,
  input wire logic [7:0] tx_data,
  input wire logic module_run,
  input wire logic ten_bit_mode,
  input wire logic free_format_select,
  input wire logic fifo_mode
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  // ====
  // helpers
  logic rx_pop;
  logic rd_ok;
  logic wr_ok;
  assign rd_ok = clk_en && reg_rd;
  assign wr_ok = clk_en && reg_wr;
  assign rx_pop = rd_ok && !reg_dbg && reg_addr == ADDR_W'(isf_pkg::OFS_RXHOLD);
  // ====
  // properties
  rdata_idle_a: assert property ($past(clk_en) && !$past(reg_rd) && $past(rst_b) |-> reg_rdata == '0)
    else $error("read data not zero outside answer");
  stall_hold_a: assert property (rx_stall && !rx_pop && !reg_wr |=> rx_stall)
    else $error("held byte released without read");
  stall_free_a: assert property (rx_stall && rx_pop |=> !rx_stall)
    else $error("stall kept after receive read");
  load_cause_a: assert property (tx_load |-> $past(tx_shift_empty) && $past(clk_en) && $past(module_run))
    else $error("load without shifter request");
  tx_hold_a: assert property (!tx_load && $past(module_run) && module_run |-> $stable(tx_data))
    else $error("transmit data moved without load");
  mode_write_a: assert property (wr_ok && reg_addr == ADDR_W'(isf_pkg::OFS_MODE) |=>
    {fifo_mode, free_format_select, ten_bit_mode, module_run} == $past(reg_wdata[3:0]))
    else $error("mode outputs differ from written value");
  reserved_zero_a: assert property (rd_ok && reg_addr == ADDR_W'(isf_pkg::OFS_STATUS) |=> reg_rdata[7:6] == 2'b00)
    else $error("reserved status bits not zero");
  unmapped_zero_a: assert property (rd_ok && reg_addr > ADDR_W'(isf_pkg::OFS_IRQ_MASK) |=> reg_rdata == '0)
    else $error("unmapped read not zero");
  irq_masked_a: assert property (wr_ok && reg_addr == ADDR_W'(isf_pkg::OFS_IRQ_MASK) && reg_wdata[4:0] == 5'h00
    ##1 clk_en |=> !irq)
    else $error("interrupt high with all masked");
endmodule : isf_status_flags_assertions

bind isf_status_flags isf_status_flags_assertions #(.ADDR_W(ADDR_W)) u_isf_chk (.core_clk, .rst_b, .clk_en,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_dbg, .reg_rdata, .irq, .rx_stall, .tx_shift_empty,
  .tx_load, .tx_data, .module_run, .ten_bit_mode, .free_format_select, .fifo_mode);

// ### testbench/isf_engine_model.sv
// behavioural shift engine facing the status-flag block
// assumes the bench asks for one receive byte at a time
`timescale 1ns/10ps
module isf_engine_model (
  // clock
  input wire logic core_clk,
  // bench commands
  input wire logic go_rx,
  input wire logic [7:0] rx_val,
  input wire logic go_tx,
  // status block side
  input wire logic rx_stall,
  output logic rx_byte_done,
  output logic [7:0] rx_byte,
  output logic tx_shift_empty
);
  logic have_q = 1'b0;
  logic [7:0] pend_q = 8'h00;
  initial
  begin
    rx_byte_done = 1'b0;
    rx_byte = 8'h00;
    tx_shift_empty = 1'b0;
  end
  always @(posedge core_clk)
  begin
    tx_shift_empty <= go_tx;
    rx_byte_done <= 1'b0;
    // data is meaningless outside the pulse, so keep it moving
    rx_byte <= ~rx_byte;
    if (go_rx)
    begin
      pend_q <= rx_val;
      have_q <= 1'b1;
    end
    // stall is registered: skip the edge right after a pulse
    else if (have_q && !rx_stall && !rx_byte_done)
    begin
      rx_byte_done <= 1'b1;
      rx_byte <= pend_q;
      have_q <= 1'b0;
    end
  end
endmodule : isf_engine_model

// ### testbench/test_isf_status_flags.sv
// self-checking bench for the status-flag block
// assumes the engine model and the bound checker are compiled alongside
`timescale 1ns/10ps
module test_isf_status_flags;
  logic core_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, reg_dbg = 0, rd_d = 0;
  logic [7:0] reg_addr = 8'h00, rx_val = 8'h00, ev = 8'h00, rx_byte, tx_data, a, b, d;
  logic [15:0] reg_wdata = 16'h0000, reg_rdata;
  logic irq, rx_stall, rx_byte_done, tx_shift_empty, tx_load, go_rx = 0, go_tx = 0;
  logic [3:0] mode;
  logic [31:0] rq[$];
  logic [7:0] tq[$];
  int err_count = 0, samples_checked = 0;
  localparam int EVI [14] = '{4, 3, 4, 1, 4, 2, 5, 0, 1, 6, 4, 3, 4, 2};
  localparam logic [15:0] EXS [14] = '{16'h0200, 16'h0000, 16'h0200, 16'h0000, 16'h0200, 16'h0020,
    16'h0320, 16'h0220, 16'h0220, 16'h0020, 16'h0220, 16'h0020, 16'h0220, 16'h0020};
  always #2.5 core_clk = ~core_clk;
  isf_status_flags dut_u (.core_clk(core_clk), .rst_b(rst_b), .clk_en(1'b1), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_dbg(reg_dbg), .reg_rdata(reg_rdata),
    .irq(irq), .rx_byte_done(rx_byte_done), .rx_byte(rx_byte), .rx_stall(rx_stall),
    .tx_shift_empty(tx_shift_empty), .tx_load(tx_load), .tx_data(tx_data), .ev_start(ev[0]),
    .ev_rstart(ev[1]), .ev_stop(ev[2]), .ev_nack(ev[3]), .ev_own_match(ev[4]), .ev_gen_call(ev[5]),
    .ev_addr_mismatch(ev[6]), .ev_first_byte(ev[7]), .module_run(mode[0]), .ten_bit_mode(mode[1]),
    .free_format_select(mode[2]), .fifo_mode(mode[3]));
  isf_engine_model eng_u (.core_clk(core_clk), .go_rx(go_rx), .rx_val(rx_val), .go_tx(go_tx),
    .rx_stall(rx_stall), .rx_byte_done(rx_byte_done), .rx_byte(rx_byte), .tx_shift_empty(tx_shift_empty));
  // ====
  // tasks
  task automatic cmp(input logic [15:0] g, input logic [15:0] e);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("FAIL %0t got %h exp %h", $time, g, e);
    end
  endtask : cmp
  task automatic finish_test;
    if (err_count == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  task automatic rd(input logic [7:0] ad, input logic [15:0] m, input logic [15:0] e, input logic dbg = 0);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_dbg <= dbg;
    reg_addr <= ad;
    rq.push_back({m, e});
    @(posedge core_clk);
    reg_rd <= 1'b0;
    reg_dbg <= 1'b0;
  endtask : rd
  task automatic st(input logic [15:0] m, input logic [15:0] e);
    rd(8'h00, m | 16'h00C0, e);
  endtask : st
  task automatic wr(input logic [7:0] ad, input logic [15:0] v);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= ad;
    reg_wdata <= v;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic pulse(input int i, input logic rx, input logic tx);
    @(posedge core_clk);
    ev <= (i < 8) ? 8'h01 << i : 8'h00;
    go_rx <= rx;
    go_tx <= tx;
    @(posedge core_clk);
    ev <= 8'h00;
    go_rx <= 1'b0;
    go_tx <= 1'b0;
    repeat (3) @(posedge core_clk);
  endtask : pulse
  // ====
  // result watcher
  always @(posedge core_clk)
  begin
    rd_d <= reg_rd;
    if (rd_d && rq.size() > 0)
    begin
      cmp(reg_rdata & rq[0][31:16], rq[0][15:0]);
      rq.delete(0);
    end
    if (tx_load)
    begin
      if (tq.size() == 0)
        cmp(16'h0001, 16'h0000);
      else
      begin
        cmp({8'h00, tx_data}, {8'h00, tq[0]});
        tq.delete(0);
      end
    end
  end
  initial
  begin
    repeat (5000) @(posedge core_clk);
    err_count++;
    finish_test();
  end
  // ====
  // main sequence
  initial
  begin
    void'($urandom(32'h8f20));
    a = 8'($urandom);
    b = 8'($urandom);
    d = 8'($urandom);
    repeat (10) @(posedge core_clk);
    rst_b <= 1'b1;
    st(16'h0F30, 16'h0410);
    wr(8'h04, 16'h0001);
    rx_val <= a;
    pulse(8, 1, 0);
    rx_val <= b;
    pulse(8, 1, 0);
    st(16'h0800, 16'h0800);
    rd(8'h0C, 16'h00FF, {8'h00, a}, 1'b1);
    st(16'h0800, 16'h0800);
    rd(8'h0C, 16'h00FF, {8'h00, a});
    st(16'h0800, 16'h0000);
    rd(8'h0C, 16'h00FF, {8'h00, b});
    wr(8'h10, {8'h00, d});
    tq.push_back(d);
    st(16'h0410, 16'h0400);
    pulse(8, 0, 1);
    st(16'h0410, 16'h0410);
    pulse(8, 0, 1);
    st(16'h0400, 16'h0000);
    pulse(8, 0, 1);
    wr(8'h10, {8'h00, b});
    st(16'h0400, 16'h0400);
    wr(8'h04, 16'h0009);
    wr(8'h10, {8'h00, a});
    tq.push_back(a);
    pulse(8, 0, 1);
    st(16'h0010, 16'h0000);
    for (int i = 0; i < 14; i++)
    begin
      if (i == 8)
        wr(8'h04, 16'h0003);
      pulse(EVI[i], 0, 0);
      st(16'h0320, EXS[i]);
    end
    wr(8'h04, 16'h0005);
    pulse(7, 0, 0);
    st(16'h0200, 16'h0200);
    rd(8'h08, 16'h0007, 16'h0006, 1'b1);
    st(16'h0020, 16'h0020);
    rd(8'h08, 16'h0007, 16'h0006);
    st(16'h0020, 16'h0000);
    wr(8'h18, 16'h0008);
    pulse(2, 0, 0);
    cmp({15'h0000, irq}, 16'h0001);
    rd(8'h14, 16'h0008, 16'h0008);
    wr(8'h00, 16'hFFFF);
    st(16'h0FF0, 16'h0400);
    wr(8'h14, 16'h001F);
    @(posedge core_clk);
    cmp({15'h0000, irq}, 16'h0000);
    pulse(2, 0, 0);
    wr(8'h18, 16'h0000);
    wr(8'h04, 16'h0000);
    st(16'h0FF0, 16'h0410);
    rd(8'hFC, 16'hFFFF, 16'h0000);
    repeat (4) @(posedge core_clk);
    finish_test();
  end
endmodule : test_isf_status_flags
